/* rtl/pdc_consts.svh */
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PDC_ADDR_FB_HI 4'h0
`define PDC_ADDR_FB_LO 4'h1
`define PDC_ADDR_FB2_LO 4'h2
`define PDC_ADDR_FB2_MSB 4'h3
`define PDC_ADDR_REF_HI 4'h4
`define PDC_ADDR_REF_LO 4'h5
`define PDC_ADDR_S2_FB_MSB 4'h8
`define PDC_ADDR_S2_FB_LO 4'h9
`define PDC_ADDR_S1_BYP 4'hA
`define PDC_ADDR_S2_PREDIV 4'hC

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PDC_RST_FB_HI 8'h0C
`define PDC_RST_FB_LO 8'h00
`define PDC_RST_FB2_LO 8'h60
`define PDC_RST_FB2_MSB 8'h00
`define PDC_RST_REF_HI 8'h0C
`define PDC_RST_REF_LO 8'h00
`define PDC_RST_S2_FB_MSB 8'h00
`define PDC_RST_S2_FB_LO 8'h18
`define PDC_RST_S1_BYP 8'h00
`define PDC_RST_S2_PREDIV 8'h00

// ----------------------------------------------------------------
// writable bit masks, reserved bits read as zero
// ----------------------------------------------------------------
`define PDC_MASK_FB_HI 8'hFF
`define PDC_MASK_FB2_MSB 8'h81
`define PDC_MASK_REF_HI 8'hEF
`define PDC_MASK_S2_FB_MSB 8'h01
`define PDC_MASK_S1_BYP 8'h01
`define PDC_MASK_S2_PREDIV 8'hBF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PDC_PHASE_MSB 7
`define PDC_PHASE_LSB 5
`define PDC_FB2_PD_BIT 4
`define PDC_HI_NIB_MSB 3
`define PDC_FB2_MSB_BIT 7
`define PDC_CASCADE_BIT 0
`define PDC_S2_FB_MSB_BIT 0
`define PDC_S1_BYP_BIT 0
`define PDC_DOUBLER_BIT 7
`define PDC_PREDIV_MSB 5

`endif

/* rtl/pdc_pkg.sv */
package pdc_pkg;
  typedef logic [11:0] pdc_div12_t;
  typedef logic [8:0] pdc_div9_t;
  typedef logic [5:0] pdc_div6_t;
  typedef logic [7:0] pdc_byte_t;
  typedef logic [3:0] pdc_addr_t;
endpackage : pdc_pkg

/* rtl/pdc_divider.sv */
`timescale 1ns/1ps
module pdc_divider #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // input clock edges and setup
  input wire logic tick_in,
  input wire logic enable_in,
  input wire logic [W-1:0] div_in,
  // divided output
  output logic tc_out,
  output logic level_out
);
  logic [W-1:0] count_ff;
  logic [W-1:0] div_ff;
  logic [W-1:0] eff;
  logic [W-1:0] nxt_count;
  logic last;

  // a zero ratio counts as one so the counter can never hang
  function automatic logic [W-1:0] eff_ratio(input logic [W-1:0] n);
    eff_ratio = (n == '0) ? {{(W-1){1'b0}}, 1'b1} : n;
  endfunction : eff_ratio

  always_comb begin
    eff = eff_ratio(div_ff);
    last = (count_ff >= eff - 1'b1);
    nxt_count = last ? '0 : count_ff + 1'b1;
  end

  // one output period per N input periods; new ratio taken at terminal count
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_ff <= '0;
      div_ff <= '0;
      tc_out <= 1'b0;
      level_out <= 1'b0;
    end else if (!enable_in) begin
      count_ff <= '0;
      tc_out <= 1'b0;
      level_out <= 1'b0;
    end else if (tick_in) begin
      count_ff <= nxt_count;
      tc_out <= last;
      level_out <= (nxt_count < ((eff + 1'b1) >> 1));
      if (last) begin
        div_ff <= div_in;
      end
    end else begin
      tc_out <= 1'b0;
    end
  end

  a_tc_needs_tick: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    tc_out |-> $past(tick_in) && $past(enable_in)) else $error("divider pulse without input edge");
  a_count_bound: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $past(tick_in) && $past(enable_in) && $past(div_ff) != '0 |-> count_ff < $past(div_ff))
    else $error("divider count passed its ratio");
endmodule : pdc_divider

/* rtl/pdc_top.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "pdc_consts.svh"
// Contract
// - primary feedback divider, 12 bits, 1 to 4095, regs fb_div_hi_phase_pd/fb_div_lo, reset 3072.
// - secondary feedback divider, 9 bits, 4 to 511, msb at fb2_div_msb_bypass bit7, reset 96.
// - secondary powerdown bit set stops and disables the secondary divider.
// - reference pre-divider, 12 bits, 1 to 4095, regs ref_div_hi_phase/ref_div_lo, reset 3072.
// - reference phase field sets lock-detect sampling phase, chosen by software.
// - feedback phase field with reference phase sets lock-detect window, software chosen.
// - stage-two feedback divider, 9 bits, 8 to 511, regs stage2_fb_div_msb/stage2_fb_div_lo, reset 24.
// - stage-two pre-divider divides by 1 to 63; zero bypasses it.
// - doubler select zero uses pre-divided mux output, one doubles it.
// - cascade select zero uses primary only; one cascades primary and secondary.
// - stage-one bypass select one disables loop and passes bypass path.
module pdc_top import pdc_pkg::*; (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // clocks to divide, sampled levels
  input wire logic ref_clk_in,
  input wire logic vcxo_clk_in,
  input wire logic synth_clk_in,
  // divided pulses
  output logic ref_pd_tick_out,
  output logic fb_pd_tick_out,
  output logic stage2_in_tick_out,
  output logic stage2_fb_tick_out,
  // stage-one mux and controls
  output logic stage1_mux_out,
  output logic stage1_bypass_out,
  output logic fb_cascade_out,
  output logic secondary_pd_out,
  output logic [2:0] feedback_sample_phase_out,
  output logic [2:0] reference_sample_phase_out
);
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  pdc_byte_t fb_hi_ff;
  pdc_byte_t fb_lo_ff;
  pdc_byte_t fb2_lo_ff;
  pdc_byte_t fb2_msb_ff;
  pdc_byte_t ref_hi_ff;
  pdc_byte_t ref_lo_ff;
  pdc_byte_t s2_fb_msb_ff;
  pdc_byte_t s2_fb_lo_ff;
  pdc_byte_t s1_byp_ff;
  pdc_byte_t s2_prediv_ff;
  pdc_byte_t nxt_rdata;

  function automatic pdc_byte_t read_map(input pdc_addr_t a, input pdc_byte_t r0, input pdc_byte_t r1,
                                         input pdc_byte_t r2, input pdc_byte_t r3, input pdc_byte_t r4,
                                         input pdc_byte_t r5, input pdc_byte_t r8, input pdc_byte_t r9,
                                         input pdc_byte_t ra, input pdc_byte_t rc);
    case (a)
      `PDC_ADDR_FB_HI: read_map = r0;
      `PDC_ADDR_FB_LO: read_map = r1;
      `PDC_ADDR_FB2_LO: read_map = r2;
      `PDC_ADDR_FB2_MSB: read_map = r3;
      `PDC_ADDR_REF_HI: read_map = r4;
      `PDC_ADDR_REF_LO: read_map = r5;
      `PDC_ADDR_S2_FB_MSB: read_map = r8;
      `PDC_ADDR_S2_FB_LO: read_map = r9;
      `PDC_ADDR_S1_BYP: read_map = ra;
      `PDC_ADDR_S2_PREDIV: read_map = rc;
      default: read_map = 8'h00;
    endcase
  endfunction : read_map

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fb_hi_ff <= `PDC_RST_FB_HI;
      fb_lo_ff <= `PDC_RST_FB_LO;
      fb2_lo_ff <= `PDC_RST_FB2_LO;
      fb2_msb_ff <= `PDC_RST_FB2_MSB;
      ref_hi_ff <= `PDC_RST_REF_HI;
      ref_lo_ff <= `PDC_RST_REF_LO;
      s2_fb_msb_ff <= `PDC_RST_S2_FB_MSB;
      s2_fb_lo_ff <= `PDC_RST_S2_FB_LO;
      s1_byp_ff <= `PDC_RST_S1_BYP;
      s2_prediv_ff <= `PDC_RST_S2_PREDIV;
    end else if (wr_in) begin
      case (addr_in)
        `PDC_ADDR_FB_HI: fb_hi_ff <= wdata_in & `PDC_MASK_FB_HI;
        `PDC_ADDR_FB_LO: fb_lo_ff <= wdata_in;
        `PDC_ADDR_FB2_LO: fb2_lo_ff <= wdata_in;
        `PDC_ADDR_FB2_MSB: fb2_msb_ff <= wdata_in & `PDC_MASK_FB2_MSB;
        `PDC_ADDR_REF_HI: ref_hi_ff <= wdata_in & `PDC_MASK_REF_HI;
        `PDC_ADDR_REF_LO: ref_lo_ff <= wdata_in;
        `PDC_ADDR_S2_FB_MSB: s2_fb_msb_ff <= wdata_in & `PDC_MASK_S2_FB_MSB;
        `PDC_ADDR_S2_FB_LO: s2_fb_lo_ff <= wdata_in;
        `PDC_ADDR_S1_BYP: s1_byp_ff <= wdata_in & `PDC_MASK_S1_BYP;
        `PDC_ADDR_S2_PREDIV: s2_prediv_ff <= wdata_in & `PDC_MASK_S2_PREDIV;
        default: ;
      endcase
    end
  end

  always_comb begin
    nxt_rdata = read_map(addr_in, fb_hi_ff, fb_lo_ff, fb2_lo_ff, fb2_msb_ff, ref_hi_ff, ref_lo_ff,
                         s2_fb_msb_ff, s2_fb_lo_ff, s1_byp_ff, s2_prediv_ff);
  end

  // read data stand for one cycle after each cycle with rd_in high, zero otherwise
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rd_in ? nxt_rdata : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  pdc_div12_t fb_ratio;
  pdc_div9_t fb2_ratio;
  pdc_div12_t ref_ratio;
  pdc_div9_t s2_fb_ratio;
  pdc_div6_t prediv_ratio;
  logic fb2_pd;
  logic cascade_sel;
  logic bypass_sel;
  logic doubler_sel;

  always_comb begin
    fb_ratio = {fb_hi_ff[`PDC_HI_NIB_MSB:0], fb_lo_ff};
    fb2_ratio = {fb2_msb_ff[`PDC_FB2_MSB_BIT], fb2_lo_ff};
    ref_ratio = {ref_hi_ff[`PDC_HI_NIB_MSB:0], ref_lo_ff};
    s2_fb_ratio = {s2_fb_msb_ff[`PDC_S2_FB_MSB_BIT], s2_fb_lo_ff};
    prediv_ratio = s2_prediv_ff[`PDC_PREDIV_MSB:0];
    fb2_pd = fb_hi_ff[`PDC_FB2_PD_BIT];
    cascade_sel = fb2_msb_ff[`PDC_CASCADE_BIT];
    bypass_sel = s1_byp_ff[`PDC_S1_BYP_BIT];
    doubler_sel = s2_prediv_ff[`PDC_DOUBLER_BIT];
  end

  // ----------------------------------------------------------------
  // input edge detection
  // ----------------------------------------------------------------
  logic ref_prev_ff;
  logic vcxo_prev_ff;
  logic synth_prev_ff;
  logic mux_prev_ff;
  logic ref_rise;
  logic vcxo_rise;
  logic synth_rise;
  logic mux_rise;
  logic mux_edge;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ref_prev_ff <= 1'b0;
      vcxo_prev_ff <= 1'b0;
      synth_prev_ff <= 1'b0;
      mux_prev_ff <= 1'b0;
    end else begin
      ref_prev_ff <= ref_clk_in;
      vcxo_prev_ff <= vcxo_clk_in;
      synth_prev_ff <= synth_clk_in;
      mux_prev_ff <= stage1_mux_out;
    end
  end

  always_comb begin
    ref_rise = ref_clk_in & ~ref_prev_ff;
    vcxo_rise = vcxo_clk_in & ~vcxo_prev_ff;
    synth_rise = synth_clk_in & ~synth_prev_ff;
    mux_rise = stage1_mux_out & ~mux_prev_ff;
    // both edges of the mux output give twice the rate for the doubler
    mux_edge = stage1_mux_out ^ mux_prev_ff;
  end

  // ----------------------------------------------------------------
  // stage-one mux; the loop output is the vcxo, bypass passes reference
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage1_mux_out <= 1'b0;
    end else begin
      stage1_mux_out <= bypass_sel ? ref_clk_in : vcxo_clk_in;
    end
  end

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  logic ref_tc;
  logic fb_tc;
  logic fb2_tc;
  logic prediv_tc;
  logic s2_fb_tc;
  logic prediv_en;

  // the pre-divider idles while bypassed or overridden, saving toggles
  assign prediv_en = !doubler_sel && (prediv_ratio != 6'h00);

  pdc_divider #(.W(12)) u_ref_div (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .tick_in(ref_rise), .enable_in(1'b1),
    .div_in(ref_ratio), .tc_out(ref_tc), .level_out());
  pdc_divider #(.W(12)) u_fb_div (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .tick_in(vcxo_rise), .enable_in(1'b1),
    .div_in(fb_ratio), .tc_out(fb_tc), .level_out());
  pdc_divider #(.W(9)) u_fb2_div (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .tick_in(fb_tc), .enable_in(!fb2_pd),
    .div_in(fb2_ratio), .tc_out(fb2_tc), .level_out());
  pdc_divider #(.W(6)) u_prediv (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .tick_in(mux_rise), .enable_in(prediv_en),
    .div_in(prediv_ratio), .tc_out(prediv_tc), .level_out());
  pdc_divider #(.W(9)) u_s2_fb_div (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .tick_in(synth_rise), .enable_in(1'b1),
    .div_in(s2_fb_ratio), .tc_out(s2_fb_tc), .level_out());

  // ----------------------------------------------------------------
  // output selection and control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ref_pd_tick_out <= 1'b0;
      fb_pd_tick_out <= 1'b0;
      stage2_in_tick_out <= 1'b0;
      stage2_fb_tick_out <= 1'b0;
    end else begin
      ref_pd_tick_out <= ref_tc;
      fb_pd_tick_out <= cascade_sel ? fb2_tc : fb_tc;
      if (doubler_sel) begin
        stage2_in_tick_out <= mux_edge;
      end else if (prediv_ratio == 6'h00) begin
        stage2_in_tick_out <= mux_rise;
      end else begin
        stage2_in_tick_out <= prediv_tc;
      end
      stage2_fb_tick_out <= s2_fb_tc;
    end
  end

  // phase fields only steer the lock detector outside; software picks them
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage1_bypass_out <= 1'b0;
      fb_cascade_out <= 1'b0;
      secondary_pd_out <= 1'b0;
      feedback_sample_phase_out <= 3'h0;
      reference_sample_phase_out <= 3'h0;
    end else begin
      stage1_bypass_out <= bypass_sel;
      fb_cascade_out <= cascade_sel;
      secondary_pd_out <= fb2_pd;
      feedback_sample_phase_out <= fb_hi_ff[`PDC_PHASE_MSB:`PDC_PHASE_LSB];
      reference_sample_phase_out <= ref_hi_ff[`PDC_PHASE_MSB:`PDC_PHASE_LSB];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_read_data_map: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rd_in && addr_in == `PDC_ADDR_FB_LO |=> rdata_out == $past(fb_lo_ff))
    else $error("read of low feedback byte wrong");
  a_read_idle_zero: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !rd_in |=> rdata_out == 8'h00) else $error("read data outside read cycle");
  a_mux_select: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ##1 stage1_mux_out == ($past(bypass_sel) ? $past(ref_clk_in) : $past(vcxo_clk_in)))
    else $error("stage-one mux picked wrong path");
  a_powerdown_stops: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    fb2_pd [*3] |-> !fb2_tc) else $error("secondary divider ran while powered down");
  a_direct_feedback: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !cascade_sel && fb_tc |=> fb_pd_tick_out) else $error("primary feedback pulse lost");
  a_cascade_blocks: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cascade_sel && !fb2_tc |=> !fb_pd_tick_out) else $error("cascade passed a primary pulse");
  a_doubler_edges: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    doubler_sel && mux_edge |=> stage2_in_tick_out) else $error("doubler missed an edge");
  a_prediv_bypass: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !doubler_sel && prediv_ratio == 6'h00 |=> stage2_in_tick_out == $past(mux_rise))
    else $error("bypassed pre-divider not transparent");
  a_phase_fields: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(rd_in) && addr_in == `PDC_ADDR_REF_HI ##1 1'b1 |-> reference_sample_phase_out == rdata_out[7:5])
    else $error("reference phase output disagrees with register");

  // ----------------------------------------------------------------
  // pulse paths: each registered output is its source one cycle late
  // ----------------------------------------------------------------
  a_ref_tick_path: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ##1 ref_pd_tick_out == $past(ref_tc)) else $error("reference pulse path wrong");
  a_s2_fb_path: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ##1 stage2_fb_tick_out == $past(s2_fb_tc)) else $error("stage-two feedback pulse path wrong");
  a_cascade_path: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cascade_sel |=> fb_pd_tick_out == $past(fb2_tc)) else $error("cascaded feedback pulse wrong");
  // a divided input must not leak raw mux edges; that would look like a lock at the wrong ratio
  a_prediv_path: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !doubler_sel && prediv_ratio != 6'h00 |=> stage2_in_tick_out == $past(prediv_tc))
    else $error("pre-divided input pulse wrong");
  a_doubler_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    doubler_sel && !mux_edge |=> !stage2_in_tick_out) else $error("doubler pulsed without an edge");
  a_control_copy: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ##1 secondary_pd_out == $past(fb2_pd)) else $error("powerdown output lags its register");
  a_bypass_copy: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ##1 stage1_bypass_out == $past(bypass_sel)) else $error("bypass output lags its register");
endmodule : pdc_top

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "pdc_consts.svh"
module tb import pdc_pkg::*;;
  // ----------------------------------------------------------------
  // stimulus and design
  // ----------------------------------------------------------------
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  pdc_addr_t addr_in = 4'h0;
  pdc_byte_t wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ref_clk_in = 1'b0;
  logic vcxo_clk_in = 1'b0;
  logic synth_clk_in = 1'b0;
  logic run = 1'b0;
  logic ref_d = 1'b0;
  logic vcxo_d = 1'b0;
  pdc_byte_t rdata_out;
  logic ref_pd_tick_out, fb_pd_tick_out, stage2_in_tick_out, stage2_fb_tick_out;
  logic stage1_mux_out, stage1_bypass_out, fb_cascade_out, secondary_pd_out;
  logic [2:0] feedback_sample_phase_out, reference_sample_phase_out;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h00000061;
  pdc_byte_t rd_d;

  pdc_top DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ref_clk_in(ref_clk_in), .vcxo_clk_in(vcxo_clk_in),
    .synth_clk_in(synth_clk_in), .ref_pd_tick_out(ref_pd_tick_out), .fb_pd_tick_out(fb_pd_tick_out),
    .stage2_in_tick_out(stage2_in_tick_out), .stage2_fb_tick_out(stage2_fb_tick_out),
    .stage1_mux_out(stage1_mux_out), .stage1_bypass_out(stage1_bypass_out), .fb_cascade_out(fb_cascade_out),
    .secondary_pd_out(secondary_pd_out), .feedback_sample_phase_out(feedback_sample_phase_out),
    .reference_sample_phase_out(reference_sample_phase_out));

  always #20 clock_in = ~clock_in;

  // input clocks stay low until the dividers are programmed, else the reset ratio loads the defaults
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    ref_clk_in <= run & (cyc % 4 < 2);
    vcxo_clk_in <= run & (cyc % 6 < 3);
    synth_clk_in <= run & (cyc % 4 >= 2);
    // levels the design saw at this edge, for the mux output one cycle later
    ref_d <= ref_clk_in;
    vcxo_d <= vcxo_clk_in;
    if (cyc == 90000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [2:0] phase_of(int n);
    if (n < 32) return 3'h0;
    if (n < 64) return 3'h2;
    if (n < 128) return 3'h3;
    if (n < 256) return 3'h4;
    if (n < 512) return 3'h5;
    if (n < 1024) return 3'h6;
    return 3'h7;
  endfunction : phase_of

  function automatic int exp_s2in(int mp, int pf, logic dbl);
    if (dbl) return mp / 2;
    return mp * ((pf == 0) ? 1 : pf);
  endfunction : exp_s2in

  function automatic logic tick(int sel);
    case (sel)
      0: return ref_pd_tick_out;
      1: return fb_pd_tick_out;
      2: return stage2_in_tick_out;
      default: return stage2_fb_tick_out;
    endcase
  endfunction : tick

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check8(string nm, pdc_byte_t e, pdc_byte_t g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check8

  task automatic check_int(string nm, int e, int g);
    n_checks++;
    if (g != e) begin
      errors++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_int

  task automatic wr_reg(pdc_addr_t a, pdc_byte_t d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(pdc_addr_t a, output pdc_byte_t d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask : rd_reg

  // skips pulses made under the old ratio, then times one clean period; 0 means no pulse came
  task automatic measure(input int sel, output int iv);
    int n;
    iv = 0;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      do begin
        @(posedge clock_in);
        #1;
        n++;
      end while (tick(sel) !== 1'b1 && n < 6000);
      if (tick(sel) !== 1'b1) return;
    end
    iv = n;
  endtask : measure

  task automatic cfg(int rv, int f0, int f1, int s2, int pf, logic casc, logic pd, logic dbl, logic byp);
    pdc_div12_t r12;
    pdc_div12_t m12;
    pdc_div9_t m9;
    pdc_div9_t s9;
    pdc_div6_t p6;
    int iv[4];
    int mp;
    r12 = rv[11:0];
    m12 = f0[11:0];
    m9 = f1[8:0];
    s9 = s2[8:0];
    p6 = pf[5:0];
    wr_reg(`PDC_ADDR_FB_HI, {phase_of(f0), pd, m12[11:8]});
    wr_reg(`PDC_ADDR_FB_LO, m12[7:0]);
    wr_reg(`PDC_ADDR_FB2_LO, m9[7:0]);
    wr_reg(`PDC_ADDR_FB2_MSB, {m9[8], 6'h00, casc});
    wr_reg(`PDC_ADDR_REF_HI, {phase_of(rv), 1'b0, r12[11:8]});
    wr_reg(`PDC_ADDR_REF_LO, r12[7:0]);
    wr_reg(`PDC_ADDR_S2_FB_MSB, {7'h00, s9[8]});
    wr_reg(`PDC_ADDR_S2_FB_LO, s9[7:0]);
    wr_reg(`PDC_ADDR_S1_BYP, {7'h00, byp});
    wr_reg(`PDC_ADDR_S2_PREDIV, {dbl, 1'b0, p6});
    repeat (2) @(posedge clock_in);
    #1;
    check8("fb phase", {5'h00, phase_of(f0)}, {5'h00, feedback_sample_phase_out});
    check8("ref phase", {5'h00, phase_of(rv)}, {5'h00, reference_sample_phase_out});
    check8("ctrl bits", {5'h00, pd, casc, byp}, {5'h00, secondary_pd_out, fb_cascade_out, stage1_bypass_out});
    run = 1'b1;
    fork
      measure(0, iv[0]);
      measure(1, iv[1]);
      measure(2, iv[2]);
      measure(3, iv[3]);
    join
    mp = byp ? 4 : 6;
    check_int("ref period", 4 * rv, iv[0]);
    check_int("fb period", casc ? (pd ? 0 : 6 * f0 * f1) : 6 * f0, iv[1]);
    check_int("stage2 in period", exp_s2in(mp, pf, dbl), iv[2]);
    check_int("stage2 fb period", 4 * s2, iv[3]);
    repeat (6) begin
      @(posedge clock_in);
      #1;
      check8("mux out", {7'h00, byp ? ref_d : vcxo_d}, {7'h00, stage1_mux_out});
    end
  endtask : cfg

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  pdc_addr_t addrs[10] = '{`PDC_ADDR_FB_HI, `PDC_ADDR_FB_LO, `PDC_ADDR_FB2_LO, `PDC_ADDR_FB2_MSB,
    `PDC_ADDR_REF_HI, `PDC_ADDR_REF_LO, `PDC_ADDR_S2_FB_MSB, `PDC_ADDR_S2_FB_LO, `PDC_ADDR_S1_BYP,
    `PDC_ADDR_S2_PREDIV};
  pdc_byte_t rstv[10] = '{8'h0C, 8'h00, 8'h60, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00};
  pdc_byte_t masks[10] = '{8'hFF, 8'hFF, 8'hFF, 8'h81, 8'hEF, 8'hFF, 8'h01, 8'hFF, 8'h01, 8'hBF};
  pdc_addr_t unmapped[3] = '{4'h6, 4'hB, 4'hF};

  initial begin
    pdc_byte_t x;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd_reg(addrs[i], rd_d);
      check8("reset value", rstv[i], rd_d);
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(unmapped[i], 8'hFF);
      rd_reg(unmapped[i], rd_d);
      check8("unmapped read", 8'h00, rd_d);
    end
    for (int i = 0; i < 10; i++) begin
      x = rnd() % 256;
      wr_reg(addrs[i], x);
      rd_reg(addrs[i], rd_d);
      check8("readback", x & masks[i], rd_d);
    end
    // smallest ratios, pre-divider bypassed
    cfg(1, 1, 4, 8, 0, 1'b0, 1'b0, 1'b0, 1'b0);
    // upper bits of the reference and stage-two feedback ratios, cascade, largest pre-divider
    cfg(257, 3, 5, 256, 63, 1'b1, 1'b0, 1'b0, 1'b0);
    // cascade while powered down, doubler on the bypass path
    cfg(7, 2, 6, 9, 5, 1'b1, 1'b1, 1'b1, 1'b1);
    cfg(5, 9, 4, 11, 5, 1'b0, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      cfg(1 + rnd() % 40, 1 + rnd() % 30, 4 + rnd() % 4, 8 + rnd() % 33, rnd() % 21, (rnd() % 2) == 1, 1'b0,
        (rnd() % 2) == 1, (rnd() % 2) == 1);
    end
    tally_and_finish();
  end
endmodule : tb
